// ---- rtl/psi_pkg.sv ----
// Shared constants for the pressure sensor two-wire command port
package psi_pkg;
	// Link framing and addressing
	localparam logic [5:0] ADDR_HI   = 6'h3B;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// Command bytes
	localparam logic [7:0] CMD_RESET    = 8'h1E;
	localparam logic [7:0] CMD_ADC_READ = 8'h00;
	localparam logic [7:0] CMD_PROM     = 8'hA0;
	localparam logic [7:0] CMD_CONV_P   = 8'h40;
	localparam logic [7:0] CMD_CONV_T   = 8'h50;
	localparam logic [2:0] OSR_MAX      = 3'h4;
	// Calibration memory and results
	localparam int         CAL_WORDS   = 8;
	localparam int         CAL_W       = 16;
	localparam int         RES_W       = 24;
	localparam logic [3:0] CRC4_POLY   = 4'h3;
	localparam logic [23:0] CORRUPT_MASK = 24'hFF_FFFF;
	localparam logic [23:0] RES_RESET   = 24'h00_0000;
	// Controller register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_DATA = 8'h0C;
	// Controller operations
	localparam logic [1:0] OP_WRITE   = 2'h0;
	localparam logic [1:0] OP_READ    = 2'h1;
	localparam logic [1:0] OP_RECOVER = 2'h2;
	// Timing in clock cycles
	localparam int QTR_CYC_DEF   = 3;
	localparam int CONV_UNIT_DEF = 64;
endpackage : psi_pkg

// ---- rtl/psi_link_if.sv ----
// Two-wire link between controller and sensor, open-drain resolved
interface psi_link_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl_line;
	logic sda_line;

	// Pulled up unless an enabled driver pulls low
	assign scl_line = !(!host_scl_oe_n && !host_scl_o);
	assign sda_line = !((!host_sda_oe_n && !host_sda_o)
		|| (!dev_sda_oe_n && !dev_sda_o));

	modport dev (input scl_line, input sda_line,
		output dev_sda_o, output dev_sda_oe_n);
	modport host (input scl_line, input sda_line,
		output host_scl_o, output host_scl_oe_n,
		output host_sda_o, output host_sda_oe_n);
endinterface : psi_link_if

// ---- rtl/psi_dev.sv ----
// Sensor end: two-wire slave, command decoder, conversion and cal memory
//
// Chosen here: the conversion time unit and the default calibration memory image.
module psi_dev #(
	parameter int unsigned  CONV_UNIT_CYC = psi_pkg::CONV_UNIT_DEF,
	parameter logic [127:0] CAL_INIT      =
		128'h0123_4567_89AB_CDEF_1357_9BDF_2468_ACE0
) (
	// System
	input  wire logic                     clock,
	input  wire logic                     nrst,
	// Two-wire link
	psi_link_if.dev                       link,
	// Straps
	input  wire logic                     protocol_select_pin,
	input  wire logic                     chip_select_n_pin,
	// Converter side
	input  wire logic [psi_pkg::RES_W-1:0] raw_pressure_value,
	input  wire logic [psi_pkg::RES_W-1:0] raw_temperature_value,
	output logic                          conv_busy,
	output logic                          conv_is_temp
);
	import psi_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ACK_A, S_WR, S_ACK_W, S_RD, S_ACK_R, S_SKIP
	} psi_dev_state_t;

	// CRC-4 over the image with the check nibble excluded
	function automatic logic [3:0] psi_crc4(input logic [127:0] img);
		logic [3:0] c;
		logic       fb;
		c = 4'h0;
		for (int i = 127; i >= 4; i--) begin
			fb = c[3] ^ img[i];
			c = {c[2:0], 1'b0} ^ (fb ? CRC4_POLY : 4'h0);
		end
		return c;
	endfunction : psi_crc4

	////////////////////////////////////////////////////////////////////
	// Synchronisers and line events
	logic [2:0]           scl_sh;
	logic [2:0]           sda_sh;
	logic [1:0]           ps_sh;
	logic [1:0]           csn_sh;
	psi_dev_state_t       state_reg, state_next;
	logic [3:0]           cnt_reg, cnt_next;
	logic [7:0]           sh_reg, sh_next;
	logic [7:0]           tx_reg, tx_next;
	logic [23:0]          word_reg, word_next;
	logic                 oen_reg, oen_next;
	logic                 rw_reg, rw_next;
	logic [CAL_W-1:0]     cal_mem [CAL_WORDS];
	logic [31:0]          conv_cnt_reg;
	logic                 corrupt_reg;
	logic                 valid_reg;
	logic [23:0]          result_reg;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			scl_sh <= 3'h7;
			sda_sh <= 3'h7;
			ps_sh  <= 2'h0;
			csn_sh <= 2'h3;
		end else begin
			scl_sh <= {scl_sh[1:0], link.scl_line};
			sda_sh <= {sda_sh[1:0], link.sda_line};
			ps_sh  <= {ps_sh[0], protocol_select_pin};
			csn_sh <= {csn_sh[0], chip_select_n_pin};
		end
	end

	// Edge and condition detection on synchronised lines
	wire logic scl_rise  = scl_sh[1] & ~scl_sh[2];
	wire logic scl_fall  = ~scl_sh[1] & scl_sh[2];
	wire logic sda_in    = sda_sh[1];
	wire logic start_det = scl_sh[1] & scl_sh[2]
		& ~sda_sh[1] & sda_sh[2];
	wire logic stop_det  = scl_sh[1] & scl_sh[2]
		& sda_sh[1] & ~sda_sh[2];
	wire logic i2c_on    = ps_sh[1];
	wire logic addr_ok   = sh_reg[7:1]
		== {ADDR_HI, ~csn_sh[1]};

	////////////////////////////////////////////////////////////////////
	// Command decode
	wire logic cmd_take = i2c_on & ~start_det & ~stop_det
		& (state_reg == S_WR) & scl_fall & (cnt_reg == BYTE_BITS);
	wire logic [7:0] cmd = sh_reg;
	wire logic is_reset  = cmd == CMD_RESET;
	wire logic is_adc_rd = cmd == CMD_ADC_READ;
	wire logic is_prom   = cmd[7:4] == CMD_PROM[7:4] & ~cmd[0];
	wire logic [2:0] cmd_arg = cmd[3:1];
	wire logic is_conv   = (cmd[7:4] == CMD_CONV_P[7:4]
		| cmd[7:4] == CMD_CONV_T[7:4])
		& ~cmd[0] & (cmd_arg <= OSR_MAX);
	wire logic do_reset  = cmd_take & is_reset;
	wire logic do_conv   = cmd_take & is_conv;
	wire logic do_adc_rd = cmd_take & is_adc_rd;
	// Word queued for the next read message, MSB first
	wire logic [23:0] res_out = (valid_reg & ~conv_busy)
		? result_reg : RES_RESET;
	wire logic [23:0] cmd_word = is_adc_rd ? res_out
		: is_prom ? {cal_mem[cmd_arg], 8'h00}
		: RES_RESET;
	wire logic [3:0] cal_crc = psi_crc4(CAL_INIT);
	wire logic [127:0] cal_image = {CAL_INIT[127:4], cal_crc};
	wire logic [23:0] raw_sel = conv_is_temp
		? raw_temperature_value : raw_pressure_value;

	////////////////////////////////////////////////////////////////////
	// Calibration memory, reloaded by reset command
	always_ff @(posedge clock) begin
		if (!nrst || do_reset) begin
			for (int w = 0; w < CAL_WORDS; w++) begin
				cal_mem[w] <= cal_image[127-CAL_W*w -: CAL_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	always_ff @(posedge clock) begin
		if (!nrst || do_reset) begin
			conv_busy    <= 1'b0;
			conv_is_temp <= 1'b0;
			conv_cnt_reg <= 32'h0000_0000;
			corrupt_reg  <= 1'b0;
			valid_reg    <= 1'b0;
			result_reg   <= RES_RESET;
		end else if (do_conv) begin
			conv_busy    <= 1'b1;
			conv_is_temp <= cmd[4];
			conv_cnt_reg <= 32'(CONV_UNIT_CYC) << cmd_arg;
			corrupt_reg  <= conv_busy;
			valid_reg    <= 1'b0;
		end else begin
			if (conv_busy && conv_cnt_reg <= 32'h0000_0001) begin
				conv_busy  <= 1'b0;
				valid_reg  <= ~do_adc_rd;
				result_reg <= raw_sel
					^ (corrupt_reg ? CORRUPT_MASK : RES_RESET);
			end else if (conv_busy) begin
				conv_cnt_reg <= conv_cnt_reg - 32'h0000_0001;
			end
			if (do_adc_rd) begin
				valid_reg <= 1'b0;
				if (conv_busy) begin
					corrupt_reg <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Two-wire slave state machine, next state
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		tx_next    = tx_reg;
		word_next  = cmd_take ? cmd_word : word_reg;
		oen_next   = oen_reg;
		rw_next    = rw_reg;
		if (!i2c_on || stop_det) begin
			state_next = S_IDLE;
			oen_next   = 1'b1;
		end else if (start_det) begin
			state_next = S_ADDR;
			cnt_next   = 4'h0;
			oen_next   = 1'b1;
		end else begin
			case (state_reg)
			S_ADDR, S_WR: begin
				if (scl_rise) begin
					sh_next  = {sh_reg[6:0], sda_in};
					cnt_next = cnt_reg + 4'h1;
				end else if (scl_fall && cnt_reg == BYTE_BITS) begin
					if (state_reg == S_WR) begin
						oen_next   = 1'b0;
						state_next = S_ACK_W;
					end else if (addr_ok) begin
						oen_next   = 1'b0;
						rw_next    = sh_reg[0];
						state_next = S_ACK_A;
					end else begin
						state_next = S_SKIP;
					end
				end
			end
			S_ACK_A, S_ACK_W: begin
				if (scl_fall) begin
					cnt_next = 4'h0;
					if (state_reg == S_ACK_A && rw_reg) begin
						tx_next    = word_reg[23:16];
						word_next  = {word_reg[15:0], 8'h00};
						oen_next   = word_reg[23];
						state_next = S_RD;
					end else begin
						oen_next   = 1'b1;
						state_next = S_WR;
					end
				end
			end
			S_RD: begin
				if (scl_rise) begin
					cnt_next = cnt_reg + 4'h1;
				end else if (scl_fall && cnt_reg == BYTE_BITS) begin
					oen_next   = 1'b1;
					state_next = S_ACK_R;
				end else if (scl_fall) begin
					oen_next = tx_reg[6];
					tx_next  = {tx_reg[6:0], 1'b0};
				end
			end
			S_ACK_R: begin
				if (scl_rise && sda_in) begin
					state_next = S_SKIP;
				end else if (scl_fall) begin
					cnt_next   = 4'h0;
					tx_next    = word_reg[23:16];
					word_next  = {word_reg[15:0], 8'h00};
					oen_next   = word_reg[23];
					state_next = S_RD;
				end
			end
			default: begin
				oen_next = 1'b1;
			end
			endcase
		end
	end

	// Slave state registers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			tx_reg    <= 8'h00;
			word_reg  <= RES_RESET;
			oen_reg   <= 1'b1;
			rw_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			tx_reg    <= tx_next;
			word_reg  <= word_next;
			oen_reg   <= oen_next;
			rw_reg    <= rw_next;
		end
	end

	// Open-drain data pin
	assign link.dev_sda_o    = 1'b0;
	assign link.dev_sda_oe_n = oen_reg;
endmodule : psi_dev

// ---- rtl/psi_host.sv ----
// Controller end: APB registers driving the two-wire master engine
module psi_host #(
	parameter int unsigned QTR_CYC = psi_pkg::QTR_CYC_DEF
) (
	// System
	input  wire logic        clock,
	input  wire logic        nrst,
	// Two-wire link
	psi_link_if.host         link,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	import psi_pkg::*;

	typedef enum logic [2:0] {
		E_IDLE, E_PULSE, E_START, E_SLOT, E_STOP
	} psi_eng_state_t;

	psi_eng_state_t est_reg, est_next;
	logic [1:0]     op_reg;
	logic [1:0]     nbytes_reg;
	logic [7:0]     cmd_reg;
	logic           csel_reg;
	logic [1:0]     hs;
	logic [15:0]    tq_reg;
	logic [1:0]     q_reg;
	logic [3:0]     slot_reg, slot_next;
	logic [1:0]     idx_reg, idx_next;
	logic           scl_oen_reg, scl_oen_next;
	logic           sda_oen_reg, sda_oen_next;
	logic           nack_reg, nack_next;
	logic           recd_reg, recd_next;
	logic [23:0]    rdata_reg, rdata_next;

	////////////////////////////////////////////////////////////////////
	// APB decode
	wire logic acc     = psel & penable;
	wire logic wr_hit  = acc & pready & pwrite;
	wire logic busy    = est_reg != E_IDLE;
	wire logic go      = wr_hit & (paddr == REG_CTRL) & ~busy;
	wire logic map_ok  = paddr == REG_CTRL | paddr == REG_CMD
		| paddr == REG_STAT | paddr == REG_DATA;
	wire logic [31:0] rd_mux =
		paddr == REG_CTRL ? {28'h000_0000, nbytes_reg, op_reg}
		: paddr == REG_CMD ? {23'h00_0000, csel_reg, cmd_reg}
		: paddr == REG_STAT ? {30'h0000_0000, nack_reg, busy}
		: paddr == REG_DATA ? {8'h00, rdata_reg}
		: 32'h0000_0000;

	// Bus answer one cycle into the access phase
	always_ff @(posedge clock) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & ~map_ok;
			prdata  <= (acc & ~pready) ? rd_mux : 32'h0000_0000;
		end
	end

	// Configuration registers, locked while busy
	always_ff @(posedge clock) begin
		if (!nrst) begin
			op_reg     <= OP_WRITE;
			nbytes_reg <= 2'h0;
			cmd_reg    <= CMD_RESET;
			csel_reg   <= 1'b0;
		end else if (go) begin
			op_reg     <= pwdata[1:0];
			nbytes_reg <= pwdata[3:2];
		end else if (wr_hit && paddr == REG_CMD && !busy) begin
			cmd_reg  <= pwdata[7:0];
			csel_reg <= pwdata[8];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bit timing and byte selection
	wire logic tick     = tq_reg == 16'(QTR_CYC - 1);
	wire logic sda_s    = hs[1];
	wire logic is_read  = op_reg == OP_READ;
	wire logic rd_byte  = is_read & (idx_reg != 2'h0);
	wire logic [7:0] tx_byte = idx_reg == 2'h0
		? {ADDR_HI, csel_reg, is_read}
		: (op_reg == OP_RECOVER ? CMD_RESET : cmd_reg);
	wire logic last_byte = is_read ? idx_reg == nbytes_reg
		: idx_reg == 2'h1;
	wire logic drive_bit = slot_reg == BYTE_BITS
		? (rd_byte ? last_byte : 1'b1)
		: (rd_byte ? 1'b1 : tx_byte[~slot_reg[2:0]]);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			hs     <= 2'h3;
			tq_reg <= 16'h0000;
			q_reg  <= 2'h0;
		end else begin
			hs <= {hs[0], link.sda_line};
			if (go || tick || !busy) begin
				tq_reg <= 16'h0000;
			end else begin
				tq_reg <= tq_reg + 16'h0001;
			end
			if (go) begin
				q_reg <= 2'h0;
			end else if (tick && busy) begin
				q_reg <= q_reg + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Engine next state; quarter k ends with its action
	always_comb begin
		est_next     = est_reg;
		slot_next    = slot_reg;
		idx_next     = idx_reg;
		scl_oen_next = scl_oen_reg;
		sda_oen_next = sda_oen_reg;
		nack_next    = nack_reg;
		recd_next    = recd_reg;
		rdata_next   = rdata_reg;
		if (go) begin
			est_next   = pwdata[1:0] == OP_RECOVER ? E_PULSE : E_START;
			slot_next  = 4'h0;
			idx_next   = 2'h0;
			nack_next  = 1'b0;
			recd_next  = 1'b0;
			rdata_next = 24'h00_0000;
		end else if (tick) begin
			case (est_reg)
			E_PULSE: begin
				if (q_reg == 2'h1) begin
					scl_oen_next = 1'b1;
				end else if (q_reg == 2'h3) begin
					scl_oen_next = 1'b0;
					slot_next    = slot_reg + 4'h1;
					if (slot_reg == BYTE_BITS) begin
						est_next = E_STOP;
					end
				end
			end
			E_START: begin
				if (q_reg == 2'h0) begin
					sda_oen_next = 1'b1;
					scl_oen_next = 1'b1;
				end else if (q_reg == 2'h2) begin
					sda_oen_next = 1'b0;
				end else if (q_reg == 2'h3) begin
					scl_oen_next = 1'b0;
					slot_next    = 4'h0;
					est_next     = E_SLOT;
				end
			end
			E_SLOT: begin
				if (q_reg == 2'h0) begin
					sda_oen_next = drive_bit;
				end else if (q_reg == 2'h1) begin
					scl_oen_next = 1'b1;
				end else if (q_reg == 2'h2) begin
					if (slot_reg != BYTE_BITS && rd_byte) begin
						rdata_next = {rdata_reg[22:0], sda_s};
					end else if (slot_reg == BYTE_BITS && !rd_byte) begin
						nack_next = sda_s;
					end
				end else begin
					scl_oen_next = 1'b0;
					slot_next    = slot_reg + 4'h1;
					if (slot_reg == BYTE_BITS) begin
						slot_next = 4'h0;
						idx_next  = idx_reg + 2'h1;
						if (nack_reg || last_byte) begin
							est_next = E_STOP;
						end
					end
				end
			end
			E_STOP: begin
				if (q_reg == 2'h0) begin
					sda_oen_next = 1'b0;
				end else if (q_reg == 2'h1) begin
					scl_oen_next = 1'b1;
				end else if (q_reg == 2'h2) begin
					sda_oen_next = 1'b1;
				end else if (op_reg == OP_RECOVER && !recd_reg) begin
					recd_next = 1'b1;
					idx_next  = 2'h0;
					est_next  = E_START;
				end else begin
					est_next = E_IDLE;
				end
			end
			default: begin
				est_next = E_IDLE;
			end
			endcase
		end
	end

	// Engine registers
	always_ff @(posedge clock) begin
		if (!nrst) begin
			est_reg     <= E_IDLE;
			slot_reg    <= 4'h0;
			idx_reg     <= 2'h0;
			scl_oen_reg <= 1'b1;
			sda_oen_reg <= 1'b1;
			nack_reg    <= 1'b0;
			recd_reg    <= 1'b0;
			rdata_reg   <= 24'h00_0000;
		end else begin
			est_reg     <= est_next;
			slot_reg    <= slot_next;
			idx_reg     <= idx_next;
			scl_oen_reg <= scl_oen_next;
			sda_oen_reg <= sda_oen_next;
			nack_reg    <= nack_next;
			recd_reg    <= recd_next;
			rdata_reg   <= rdata_next;
		end
	end

	// Open-drain pins
	assign link.host_scl_o    = 1'b0;
	assign link.host_sda_o    = 1'b0;
	assign link.host_scl_oe_n = scl_oen_reg;
	assign link.host_sda_oe_n = sda_oen_reg;
endmodule : psi_host

// ---- tb/psi_link_sva.sv ----
// Checker for the two-wire link between controller and sensor
module psi_link_sva #(
	parameter int unsigned CONV_UNIT_CYC = 64
) (
	// System
	input wire logic clock,
	input wire logic nrst,
	// Link drivers and resolved lines
	input wire logic host_scl_o,
	input wire logic host_sda_o,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic scl_line,
	input wire logic sda_line,
	// Straps and converter status
	input wire logic chip_select_n_pin,
	input wire logic protocol_select_pin,
	input wire logic conv_busy,
	input wire logic conv_is_temp
);
	import psi_pkg::*;
	logic        scl_q, sda_q, in_frame, first, rd, ackd;
	logic [3:0]  bitn;
	logic [7:0]  sh;
	logic [31:0] bcnt;
	wire logic   rise, start_c, stop_c, byte_end, wr_end, conv_cmd;

	// Line events seen on the resolved wires
	assign rise     = scl_line && !scl_q;
	assign start_c  = scl_line && scl_q && sda_q && !sda_line;
	assign stop_c   = scl_line && scl_q && !sda_q && sda_line;
	assign byte_end = rise && in_frame && bitn == 4'h8;
	assign wr_end   = byte_end && !first && !rd && ackd;
	assign conv_cmd = sh[7:5] == 3'h2 && !sh[0] && sh[3:0] <= 4'h8;

	// Line history and conversion length
	always_ff @(posedge clock) begin
		scl_q <= nrst ? scl_line : 1'h1;
		sda_q <= nrst ? sda_line : 1'h1;
		bcnt  <= (nrst && conv_busy) ? bcnt + 32'h0000_0001 : '0;
	end

	// Frame, bit and byte tracking
	always_ff @(posedge clock) begin
		if (!nrst || start_c) begin
			in_frame <= nrst;
			first    <= 1'h1;
			rd       <= 1'h0;
			ackd     <= 1'h0;
			bitn     <= 4'h0;
			sh       <= 8'h00;
		end else if (stop_c) begin
			in_frame <= 1'h0;
		end else if (byte_end) begin
			bitn  <= 4'h0;
			first <= 1'h0;
			ackd  <= first ? !sda_line : ackd;
		end else if (rise && in_frame) begin
			bitn <= bitn + 4'h1;
			sh   <= {sh[6:0], sda_line};
			rd   <= (first && bitn == 4'h7) ? sda_line : rd;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	a_open_drain: assert property (
		!host_scl_o && !host_sda_o && !dev_sda_o)
		else $error("link driver drives a high level");
	a_dev_edge_low: assert property (
		$changed(dev_sda_oe_n) |-> !scl_line && !scl_q)
		else $error("sensor changed data while clock high");
	a_scl_high_len: assert property (
		$rose(scl_line) |-> scl_line[*5])
		else $error("clock high phase too short");
	a_dev_in_frame: assert property (
		!dev_sda_oe_n |-> in_frame)
		else $error("sensor drives data outside a message");
	a_slot_drive: assert property (
		rise && in_frame && !dev_sda_oe_n
		|-> ((rd && !first) ? bitn != 4'h8 : bitn == 4'h8))
		else $error("sensor drives data in wrong bit slot");
	a_addr_match: assert property (
		byte_end && first |-> !dev_sda_oe_n == (sh[7:2] == ADDR_HI
		&& sh[1] == !chip_select_n_pin && protocol_select_pin))
		else $error("address acknowledge wrong");
	a_busy_bound: assert property (
		bcnt <= (CONV_UNIT_CYC << 4) + 32'h0000_0002)
		else $error("conversion busy too long");
	a_reset_cmd: assert property (
		wr_end && sh == CMD_RESET |-> ##[1:60] !conv_busy)
		else $error("reset command left conversion running");
	a_conv_start: assert property (
		wr_end && conv_cmd
		|-> ##[1:60] (conv_busy && conv_is_temp == sh[4]))
		else $error("conversion command did not start conversion");
endmodule : psi_link_sva

// ---- tb/tb_pressure_sensor_i2c_command_port.sv ----
// Bench joining controller and sensor over the two-wire link
module tb_pressure_sensor_i2c_command_port;
	timeunit 1ns;
	timeprecision 1ns;
	import psi_pkg::*;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [1:0]  n;
		logic [23:0] exp;
	} psi_row_t;
	localparam logic [127:0] CAL_IMG =
		128'hFEDC_0A1B_2C3D_4E5F_6071_8293_A4B5_C6D0;
	localparam int unsigned CONV_UNIT = 32;
	logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
	logic        protocol_select_pin, chip_select_n_pin;
	logic        conv_busy, conv_is_temp, a0, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [23:0] raw_pressure_value, raw_temperature_value;
	int          fails, cmp_count;
	psi_row_t    rows [18];

	// Both ends and the link between them
	psi_link_if u_psi_link_if();
	psi_dev #(.CONV_UNIT_CYC(CONV_UNIT), .CAL_INIT(CAL_IMG)) u_psi_dev (
		.clock, .nrst, .link(u_psi_link_if.dev), .protocol_select_pin,
		.chip_select_n_pin, .raw_pressure_value, .raw_temperature_value,
		.conv_busy, .conv_is_temp);
	psi_host u_psi_host (.clock, .nrst, .link(u_psi_link_if.host), .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	psi_link_sva #(.CONV_UNIT_CYC(CONV_UNIT)) u_psi_link_sva (
		.clock, .nrst, .host_scl_o(u_psi_link_if.host_scl_o),
		.host_sda_o(u_psi_link_if.host_sda_o),
		.dev_sda_o(u_psi_link_if.dev_sda_o),
		.dev_sda_oe_n(u_psi_link_if.dev_sda_oe_n),
		.scl_line(u_psi_link_if.scl_line),
		.sda_line(u_psi_link_if.sda_line), .chip_select_n_pin,
		.protocol_select_pin, .conv_busy, .conv_is_temp);

	// Clock
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////
	// Verdict, compare and bus tasks
	task test_done;
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			chk(32'(n), 32'h0000_0000);
			test_done();
		end
		rdat = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask : apb

	// Poll status until the link engine is idle
	task idle;
		int n;
		n = 0;
		do begin
			apb(1'h0, REG_STAT, 32'h0000_0000);
			n++;
		end while (rdat[0] !== 1'b0 && n < 400);
		if (n >= 400) begin
			chk(32'(n), 32'h0000_0000);
			test_done();
		end
	endtask : idle

	task op_wr(input logic [7:0] c);
		apb(1'h1, REG_CMD, {23'h00_0000, a0, c});
		apb(1'h1, REG_CTRL, 32'(OP_WRITE));
		idle();
	endtask : op_wr

	task op_rd(input logic [1:0] n);
		apb(1'h1, REG_CTRL, 32'({n, OP_READ}));
		idle();
		apb(1'h0, REG_DATA, 32'h0000_0000);
	endtask : op_rd

	task conv_wait;
		int n;
		n = 0;
		while (conv_busy !== 1'b0 && n < 2000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 2000) begin
			chk(32'(n), 32'h0000_0000);
			test_done();
		end
	endtask : conv_wait

	function automatic logic [3:0] crc4(input logic [127:0] m);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 127; i >= 4; i--)
			c = {c[2:0], 1'b0} ^ ((c[3] ^ m[i]) ? CRC4_POLY : 4'h0);
		return c;
	endfunction : crc4

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{nrst, psel, penable, pwrite, a0, chip_select_n_pin} = 6'h01;
		protocol_select_pin = 1'h1;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		raw_pressure_value = 24'h00_0000;
		raw_temperature_value = 24'h00_0000;
		fails = 0;
		cmp_count = 0;
		for (int i = 0; i < 8; i++)
			rows[i] = '{CMD_PROM + 8'(2 * i), 2'h2,
				{8'h00, CAL_IMG[127 - 16 * i -: 16]}};
		rows[7].exp[3:0] = crc4(CAL_IMG);
		for (int i = 0; i < 10; i++)
			rows[8 + i] = '{(i < 5 ? CMD_CONV_P : CMD_CONV_T)
				+ 8'(2 * (i % 5)), 2'h3, {8'(i + 1), 16'hC3A5}};
		repeat (6) @(posedge clock);
		nrst <= 1'h1;
		repeat (3) @(posedge clock);
		// Reset status and unmapped place
		apb(1'h0, REG_STAT, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		apb(1'h0, 8'h10, 32'h0000_0000);
		chk({rdat[30:0], e}, 32'h0000_0001);
		// Table of memory reads and conversions
		foreach (rows[i]) begin
			if (rows[i].cmd[4])
				raw_temperature_value <= rows[i].exp;
			else
				raw_pressure_value <= rows[i].exp;
			op_wr(rows[i].cmd);
			if (rows[i].cmd[6]) begin
				conv_wait();
				chk(32'(conv_is_temp), 32'(rows[i].cmd[4]));
				op_wr(CMD_ADC_READ);
			end
			op_rd(rows[i].n);
			chk(rdat, 32'(rows[i].exp));
		end
		// Repeated result read
		op_wr(CMD_ADC_READ);
		op_rd(2'h3);
		chk(rdat, 32'h0000_0000);
		// Result read during a conversion
		raw_pressure_value <= 24'h13_579B;
		op_wr(8'h48);
		op_wr(CMD_ADC_READ);
		op_rd(2'h3);
		chk(rdat, 32'h0000_0000);
		conv_wait();
		op_wr(CMD_ADC_READ);
		op_rd(2'h3);
		chk(rdat, 32'h00EC_A864);
		// Reset command aborts a conversion
		op_wr(8'h58);
		op_wr(CMD_RESET);
		chk(32'(conv_busy), 32'h0000_0000);
		op_wr(CMD_ADC_READ);
		op_rd(2'h3);
		chk(rdat, 32'h0000_0000);
		// Address bit follows chip select
		chip_select_n_pin <= 1'h0;
		repeat (4) @(posedge clock);
		op_wr(8'hA2);
		chk(32'(rdat[1]), 32'h0000_0001);
		a0 = 1'h1;
		op_wr(8'hA2);
		chk(32'(rdat[1]), 32'h0000_0000);
		op_rd(2'h2);
		chk(rdat, 32'(CAL_IMG[111:96]));
		chip_select_n_pin <= 1'h1;
		a0 = 1'h0;
		// Port silent with protocol strap low
		protocol_select_pin <= 1'h0;
		repeat (4) @(posedge clock);
		op_wr(CMD_RESET);
		chk(32'(rdat[1]), 32'h0000_0001);
		protocol_select_pin <= 1'h1;
		repeat (4) @(posedge clock);
		// Bus recovery then a memory read
		apb(1'h1, REG_CTRL, 32'(OP_RECOVER));
		idle();
		chk(32'(rdat[1]), 32'h0000_0000);
		op_wr(8'hAE);
		op_rd(2'h2);
		chk(rdat, 32'(rows[7].exp));
		// Reset in mid-run stops a conversion and clears the registers
		op_wr(8'h58);
		nrst <= 1'h0;
		repeat (6) @(posedge clock);
		nrst <= 1'h1;
		repeat (3) @(posedge clock);
		chk(32'(conv_busy), 32'h0000_0000);
		apb(1'h0, REG_CTRL, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		op_wr(8'hA4);
		op_rd(2'h2);
		chk(rdat, 32'(CAL_IMG[95:80]));
		test_done();
	end
endmodule : tb_pressure_sensor_i2c_command_port
